// file: core/core_tick_gen.sv
// core clock tick generator: one pulse per 4 MHz or 1 MHz core cycle
`timescale 1ns/1ps
`default_nettype none

module core_tick_gen
	import seq_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic core_clock_sel,
	output var  logic tick
);

	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] cnt_d;
	logic [DIV_W-1:0] lim;
	logic             tick_q;
	logic             tick_d;

	// ==========================================================
	// divider; 50/4 is not whole, so the fast core runs slightly high
	always_comb begin
		lim    = core_clock_sel ? DIV_W'(DIV_FAST - 1) : DIV_W'(DIV_SLOW - 1);
		tick_d = (cnt_q >= lim); // >= survives a change of selection
		cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
	end

	// registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule : core_tick_gen

`default_nettype wire

// file: core/measurement_mode_sequencer.sv
// measurement mode sequencer: command window, calibration and update scheduling
`timescale 1ns/1ps
`default_nettype none

module measurement_mode_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned WIN_UNLOCK = WIN_UNLOCK_CYC,
	parameter int unsigned WIN_LOCK   = WIN_LOCK_CYC,
	parameter per_tab_t    PERIOD_CYC = PERIOD_CYC_DEF,
	parameter int unsigned CONV       = CONV_CYC,
	parameter int unsigned CALC       = CALC_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire cfg_t        cfg,
	input  wire cmd_t        cmd,
	input  wire logic [13:0] bridge_data,
	input  wire logic [7:0]  temp_data,
	input  wire logic        diag_fault,
	output var  result_t     result,
	output var  logic        data_ready_int,
	output var  logic        i2c_active,
	output var  logic        cal_mode,
	output var  logic        powered_down,
	output var  logic        conv_start,
	output var  meas_t       conv_kind,
	output var  logic        cal_exec
);

	logic             tick;
	state_t           state_q;
	state_t           state_d;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	logic [TMR_W-1:0] per_q;
	logic [TMR_W-1:0] per_d;
	logic [7:0]       gap_q;
	logic [7:0]       gap_d;
	logic             alt_q;
	logic             alt_d;
	logic             full_q;
	logic             full_d;
	logic             special_q;
	logic             special_d;
	logic             fault_q;
	logic             fault_d;
	logic [7:0]       temp_q;
	logic [7:0]       temp_d;
	result_t          res_q;
	result_t          res_d;
	logic             int_q;
	logic             int_d;
	logic             i2c_q;
	logic             i2c_d;
	logic             cal_q;
	logic             cal_d;
	logic             pd_q;
	logic             pd_d;
	logic             cs_q;
	logic             cs_d;
	logic             ce_q;
	logic             ce_d;
	meas_t            kind_q;
	meas_t            kind_d;
	logic [TMR_W-1:0] stage_len;
	logic [TMR_W-1:0] per_target;
	logic [3:0]       per_idx;
	logic             expired;
	logic             start_upd;
	logic             start_full;
	logic             write_now;

	// ==========================================================
	// core clock time base
	core_tick_gen u_tick (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.core_clock_sel (cfg.core_clock_sel),
		.tick           (tick)
	);

	// ==========================================================
	// sequencer next state
	always_comb begin
		state_d    = state_q;
		tmr_d      = tmr_q;
		per_d      = per_q;
		gap_d      = gap_q;
		alt_d      = alt_q;
		full_d     = full_q;
		special_d  = special_q;
		fault_d    = fault_q;
		temp_d     = temp_q;
		res_d      = res_q;
		int_d      = int_q;
		ce_d       = 1'b0;
		start_upd  = 1'b0;
		start_full = 1'b0;
		write_now  = 1'b0;
		per_idx    = {cfg.long_integ, cfg.core_clock_sel, cfg.update_rate};
		// period grows by one conversion when it holds a special one
		per_target = TMR_W'(PERIOD_CYC[per_idx])
			+ (special_q ? TMR_W'(CONV) : '0);
		case (state_q)
			ST_WINDOW: stage_len = TMR_W'(cfg.nv_locked ? WIN_LOCK : WIN_UNLOCK);
			ST_CALC:   stage_len = TMR_W'(CALC);
			default:   stage_len = TMR_W'(CONV);
		endcase
		expired = tick && (tmr_q == stage_len - 1'b1);
		// timers advance on core ticks only
		if (tick) begin
			tmr_d = tmr_q + 1'b1;
			if (per_q != '1) begin
				per_d = per_q + 1'b1;
			end
		end
		case (state_q)
			ST_WINDOW: begin
				if (cmd.enter_calibration_cmd && cmd.from_i2c) begin
					state_d      = ST_CAL;
					res_d.status = STAT_CMD;
				end else if (expired) begin
					if (cfg.sleep_mode) begin
						state_d = ST_SLEEP;
					end else begin
						start_full = 1'b1;
					end
				end
			end
			ST_CAL: begin
				if (cmd.from_i2c && cmd.start_normal_cmd) begin
					res_d.status = STAT_STALE;
					if (cfg.sleep_mode) begin
						state_d = ST_SLEEP;
					end else begin
						start_full = 1'b1;
					end
				end else if (cmd.from_i2c && cmd.cal_other_cmd) begin
					ce_d = 1'b1;
				end
			end
			ST_TEMP: begin
				if (expired) begin
					temp_d  = temp_data;
					state_d = full_q ? ST_ZERO : ST_BRIDGE;
				end
			end
			ST_ZERO: begin
				if (expired) begin
					state_d = ST_BRIDGE;
				end
			end
			ST_BRIDGE: begin
				if (expired) begin
					state_d = ST_CALC;
				end
			end
			ST_CALC: begin
				if (expired) begin
					write_now = 1'b1;
					if (cfg.sleep_mode) begin
						state_d = ST_SLEEP;
					end else if (cfg.update_rate == 2'h0) begin
						start_upd = 1'b1;
					end else begin
						state_d = ST_PWRDN;
					end
				end
			end
			ST_SLEEP: begin
				if (cmd.wake_full_measure_cmd) begin
					start_full = 1'b1;
				end else if (cmd.wake_bridge_only_cmd && cmd.from_i2c) begin
					state_d   = ST_BRIDGE;
					special_d = 1'b0;
				end
			end
			ST_PWRDN: begin
				if (per_q >= per_target) begin
					start_upd = 1'b1;
				end
			end
			default: state_d = ST_WINDOW;
		endcase
		// start of a cycle: full sequence, or bridge with an odd special
		if (start_full) begin
			state_d   = ST_TEMP;
			full_d    = 1'b1;
			special_d = 1'b1;
			gap_d     = '0;
			per_d     = '0;
		end else if (start_upd) begin
			full_d = 1'b0;
			per_d  = '0;
			if (gap_q >= SPECIAL_GAP[cfg.update_rate]) begin
				gap_d     = '0;
				special_d = 1'b1;
				alt_d     = ~alt_q;
				state_d   = alt_q ? ST_ZERO : ST_TEMP;
			end else begin
				gap_d     = gap_q + 1'b1;
				special_d = 1'b0;
				state_d   = ST_BRIDGE;
			end
		end
		// a write in the same cycle as a fetch wins: fresh data is valid or fault, never stale
		if (write_now) begin
			fault_d      = fault_q | diag_fault;
			res_d.status = (fault_q | diag_fault) ? STAT_FAULT : STAT_VALID;
			res_d.bridge = bridge_data;
			res_d.temp   = temp_q;
			int_d        = i2c_q & ~(fault_q | diag_fault);
		end else if (cmd.fetch_result_cmd && res_q.status == STAT_VALID) begin
			res_d.status = STAT_STALE;
			int_d        = 1'b0;
		end
		if (state_d != state_q) begin
			tmr_d = '0;
		end
		cs_d   = (state_d != state_q) && (state_d inside {ST_TEMP, ST_ZERO, ST_BRIDGE});
		kind_d = (state_d == ST_TEMP) ? MEAS_TEMP :
			(state_d == ST_ZERO) ? MEAS_ZERO :
			(state_d == ST_BRIDGE) ? MEAS_BRIDGE : MEAS_NONE;
		i2c_d  = (state_d == ST_WINDOW) || (state_d == ST_CAL) || !cfg.spi_protocol;
		cal_d  = (state_d == ST_CAL);
		pd_d   = (state_d == ST_SLEEP) || (state_d == ST_PWRDN);
	end

	// ==========================================================
	// sequencer registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q   <= ST_WINDOW;
			tmr_q     <= '0;
			per_q     <= '0;
			gap_q     <= '0;
			alt_q     <= 1'b0;
			full_q    <= 1'b0;
			special_q <= 1'b0;
			fault_q   <= 1'b0;
			temp_q    <= '0;
			res_q     <= '{status: STAT_STALE, bridge: '0, temp: '0};
			int_q     <= 1'b0;
			i2c_q     <= 1'b1;
			cal_q     <= 1'b0;
			pd_q      <= 1'b0;
			cs_q      <= 1'b0;
			ce_q      <= 1'b0;
			kind_q    <= MEAS_NONE;
		end else begin
			state_q   <= state_d;
			tmr_q     <= tmr_d;
			per_q     <= per_d;
			gap_q     <= gap_d;
			alt_q     <= alt_d;
			full_q    <= full_d;
			special_q <= special_d;
			fault_q   <= fault_d;
			temp_q    <= temp_d;
			res_q     <= res_d;
			int_q     <= int_d;
			i2c_q     <= i2c_d;
			cal_q     <= cal_d;
			pd_q      <= pd_d;
			cs_q      <= cs_d;
			ce_q      <= ce_d;
			kind_q    <= kind_d;
		end
	end

	// outputs straight from the registers
	assign result         = res_q;
	assign data_ready_int = int_q;
	assign i2c_active     = i2c_q;
	assign cal_mode       = cal_q;
	assign powered_down   = pd_q;
	assign conv_start     = cs_q;
	assign conv_kind      = kind_q;
	assign cal_exec       = ce_q;

	// ==========================================================
	// checks; configuration is taken as static while running
	logic [12:0] pcnt_q;
	logic        seen_q;

	// core ticks until the first write or a calibration entry
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcnt_q <= '0;
			seen_q <= 1'b0;
		end else begin
			if (write_now || state_q == ST_CAL) begin
				seen_q <= 1'b1;
			end
			if (tick && !seen_q && pcnt_q != '1) begin
				pcnt_q <= pcnt_q + 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_por_i2c_mode: assert property (
		(state_q == ST_WINDOW) |-> i2c_active)
		else $error("not in i2c during command window");
	chk_cal_entry_cause: assert property (
		$rose(cal_mode) |-> ($past(state_q) == ST_WINDOW)
			&& $past(cmd.enter_calibration_cmd) && $past(cmd.from_i2c))
		else $error("calibration entered without window command");
	chk_cal_no_conv: assert property (
		cal_mode |-> !conv_start)
		else $error("conversion started in calibration mode");
	chk_cal_status_bus: assert property (
		cal_mode |-> i2c_active && (result.status == STAT_CMD))
		else $error("calibration mode without i2c or status 01");
	chk_cal_exit_normal: assert property (
		(state_q == ST_CAL && cmd.start_normal_cmd && cmd.from_i2c)
			|=> !cal_mode && (result.status == STAT_STALE))
		else $error("start normal did not leave calibration");
	chk_fetch_stale: assert property (
		(cmd.fetch_result_cmd && result.status == STAT_VALID && !write_now)
			|=> (result.status == STAT_STALE) && !data_ready_int)
		else $error("fetched result not marked stale");
	chk_int_fresh_data: assert property (
		$rose(data_ready_int) |-> (result.status == STAT_VALID) && i2c_active)
		else $error("data ready without fresh valid data");
	chk_fast_no_sleep: assert property (
		(!cfg.sleep_mode && cfg.update_rate == 2'h0) |-> !powered_down)
		else $error("power down at fastest rate");
	chk_special_bridge: assert property (
		(state_q == ST_ZERO && expired) |=> (state_q == ST_BRIDGE) && conv_start)
		else $error("special measurement not followed by bridge");
	chk_valid_after_calc: assert property (
		(result.status == STAT_VALID && $past(result.status) != STAT_VALID)
			|-> ($past(state_q) == ST_CALC))
		else $error("valid result before correction finished");
	chk_first_result_time: assert property (
		(cfg.nv_locked && !cfg.sleep_mode && !cfg.core_clock_sel && !seen_q)
			|-> (pcnt_q <= FIRST_RESULT_CYC))
		else $error("first result later than 6 ms");

	cov_cal_entry:  cover property (state_q == ST_WINDOW ##1 state_q == ST_CAL);
	cov_special:    cover property (state_q == ST_PWRDN ##1 state_q == ST_TEMP);
	cov_sleep_wake: cover property (state_q == ST_SLEEP ##1 state_q == ST_BRIDGE);
	cov_fetch:      cover property (cmd.fetch_result_cmd && result.status == STAT_VALID);

endmodule : measurement_mode_sequencer

`default_nettype wire

// file: dv/host_model.sv
// serial host model: command pulses and spaced result polling
`timescale 1ns/1ps
`default_nettype none

module host_model
	import seq_pkg::*;
(
	input  wire logic clk,
	output var  cmd_t cmd
);
	int unsigned gap_clk;

	initial begin
		cmd = '0;
		gap_clk = 0;
	end

	// ==========================================================
	// one-cycle pulse, launched just after an edge
	task automatic send(input cmd_t c);
		@(posedge clk);
		#1 cmd = c;
		@(posedge clk);
		#1 cmd = '0;
	endtask : send

	// polling; gap set by the bench to period plus a fifth
	always begin
		@(posedge clk);
		if (gap_clk != 0) begin
			repeat (gap_clk) @(posedge clk);
			send(7'h10);
		end
	end
endmodule : host_model

`default_nettype wire

// file: dv/measurement_mode_sequencer_tb.sv
// self-checking bench for the measurement mode sequencer
`timescale 1ns/1ps
`default_nettype none

module measurement_mode_sequencer_tb
	import seq_pkg::*;
;
	localparam int unsigned WU  = 60;
	localparam int unsigned WL  = 15;
	localparam int unsigned CV  = 5;
	localparam int unsigned CA  = 3;
	localparam int unsigned TMO = 80000;
	localparam cmd_t C_ENT = 7'h40;
	localparam cmd_t C_NOM = 7'h20;
	localparam cmd_t C_FET = 7'h10;
	localparam cmd_t C_WFU = 7'h08;
	localparam cmd_t C_WBR = 7'h04;
	localparam cmd_t C_OTH = 7'h02;
	localparam cmd_t C_I2C = 7'h01;

	// distinct short periods so a wrong table index shows
	function automatic per_tab_t mk_per();
		per_tab_t t;
		for (int i = 0; i < 16; i++) t[i] = 20 + 4 * i;
		return t;
	endfunction : mk_per
	localparam per_tab_t PER = mk_per();

	logic        clk;
	logic        sys_rst;
	cfg_t        cfg;
	cmd_t        cmd;
	logic [13:0] bd;
	logic [7:0]  td;
	logic        flt;
	result_t     result;
	logic        dri, i2c, calm, pd, cs, cx, pd_seen;
	meas_t       kind, lastk;
	int unsigned err_total, checks_done, cyc, r0, conv_n, cal_n, n;
	int unsigned ct[$];
	logic        csp[$];
	meas_t       ks[$];

	measurement_mode_sequencer #(
		.WIN_UNLOCK(WU), .WIN_LOCK(WL), .PERIOD_CYC(PER), .CONV(CV), .CALC(CA)
	) u_measurement_mode_sequencer (
		.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .cmd(cmd), .bridge_data(bd),
		.temp_data(td), .diag_fault(flt), .result(result), .data_ready_int(dri),
		.i2c_active(i2c), .cal_mode(calm), .powered_down(pd), .conv_start(cs),
		.conv_kind(kind), .cal_exec(cx));

	host_model u_host_model (.clk(clk), .cmd(cmd));

	// ==========================================================
	// monitor: a cycle starts with the first conversion after a bridge
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pd === 1'b1) pd_seen <= 1'b1;
		if (cx === 1'b1) cal_n <= cal_n + 1;
		if (cs === 1'b1) begin
			conv_n <= conv_n + 1;
			ks.push_back(kind);
			if (lastk == MEAS_BRIDGE) begin
				ct.push_back(cyc);
				csp.push_back(kind != MEAS_BRIDGE);
			end
			lastk <= kind;
		end
	end

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) if (cyc == TMO) begin
		err_total++;
		results();
	end

	// ==========================================================
	// helpers
	task automatic step(input int unsigned k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
		end
	endtask : check

	// cfg only changes under reset; bench state cleared with it
	task automatic do_reset(input cfg_t c);
		sys_rst = 1'b1;
		cfg = c;
		step(2);
		ct.delete();
		csp.delete();
		ks.delete();
		conv_n = 0;
		cal_n = 0;
		pd_seen = 1'b0;
		lastk = MEAS_BRIDGE;
		sys_rst = 1'b0;
		r0 = cyc;
	endtask : do_reset

	task automatic wait_starts(input int unsigned k);
		for (n = 0; ct.size() < k && n < 30000; n++) step(1);
	endtask : wait_starts

	task automatic wait_fresh();
		for (n = 0; result.status === STAT_STALE && n < 5000; n++) step(1);
	endtask : wait_fresh

	// ==========================================================
	// tests
	task automatic t_window();
		cfg_t c;
		int unsigned d, w;
		for (int i = 0; i < 3; i++) begin
			c = '0;
			c.nv_locked = (i != 0);
			c.core_clock_sel = (i != 1);
			c.spi_protocol = (i == 2);
			c.update_rate = 2'h1;
			d = c.core_clock_sel ? DIV_FAST : DIV_SLOW;
			w = (c.nv_locked ? WL : WU) * d;
			do_reset(c);
			check(i2c, 1'b1, "i2c at start");
			check(result.status, STAT_STALE, "reset status");
			wait_starts(1);
			check(ct[0] - r0 >= w && ct[0] - r0 <= w + d + 4, 1, "window");
			check(ks[0], MEAS_TEMP, "first kind");
			check(i2c, !c.spi_protocol, "protocol");
		end
		$display("test window done");
	endtask : t_window

	task automatic t_update(input logic [1:0] r, input logic li);
		cfg_t c;
		int unsigned p;
		c = '0;
		c.nv_locked = 1'b1;
		c.core_clock_sel = 1'b1;
		c.long_integ = li;
		c.update_rate = r;
		p = PER[{li, 1'b1, r}] * DIV_FAST;
		bd = 14'($urandom);
		td = 8'($urandom);
		do_reset(c);
		wait_fresh();
		check(result.status, STAT_VALID, "valid");
		check(result.bridge, bd, "bridge");
		check(result.temp, td, "temp");
		check(ks.size(), 3, "convs before write");
		check(ks[1], MEAS_ZERO, "second kind");
		check(ks[2], MEAS_BRIDGE, "third kind");
		step(1);
		check(dri, 1'b1, "ready pin");
		check(pd, r != 2'h0, "power down");
		u_host_model.send(C_FET | C_I2C);
		step(1);
		check(result.status, STAT_STALE, "stale");
		check(dri, 1'b0, "ready cleared");
		u_host_model.gap_clk = p * 6 / 5;
		wait_starts(r == 2'h3 ? 18 : 6);
		u_host_model.gap_clk = 0;
		if (r == 2'h0) begin
			check(pd_seen, 1'b0, "no power down");
		end else begin
			check(ct[3] - ct[2], p, "period");
			check(ks[4], MEAS_BRIDGE, "ordinary kind");
		end
		if (r == 2'h3) begin
			check({csp[15], csp[16]}, 2'h1, "special place");
			check(ks[18], MEAS_TEMP, "special kind");
			check(ks[19], MEAS_BRIDGE, "after special");
			check(ct[17] - ct[16], p + CV * DIV_FAST, "special period");
		end
		step(1200);
		$display("test update done");
	endtask : t_update

	task automatic t_cal();
		cfg_t c;
		c = '0;
		c.nv_locked = 1'b1;
		c.core_clock_sel = 1'b1;
		c.spi_protocol = 1'b1;
		c.update_rate = 2'h1;
		do_reset(c);
		u_host_model.send(C_ENT);
		check(calm, 1'b0, "entry needs i2c");
		u_host_model.send(C_ENT | C_I2C);
		check(calm, 1'b1, "cal mode");
		check(result.status, STAT_CMD, "cal status");
		u_host_model.send(C_OTH);
		u_host_model.send(C_OTH | C_I2C);
		step(1);
		check(cal_n, 1, "cal exec");
		u_host_model.send(C_FET | C_I2C);
		step(400);
		check(conv_n, 0, "no measuring");
		check(i2c, 1'b1, "cal i2c");
		check(result.status, STAT_CMD, "cal kept");
		u_host_model.send(C_NOM | C_I2C);
		check(calm, 1'b0, "leave cal");
		step(3);
		check(conv_n, 1, "normal starts");
		check(i2c, 1'b0, "spi adopted");
		$display("test calibration done");
	endtask : t_cal

	task automatic t_sleep();
		cfg_t c;
		c = '0;
		c.nv_locked = 1'b1;
		c.core_clock_sel = 1'b1;
		c.sleep_mode = 1'b1;
		do_reset(c);
		step(400);
		check(pd, 1'b1, "asleep");
		check(conv_n, 0, "waits");
		u_host_model.send(C_WFU);
		wait_fresh();
		check(ks[0], MEAS_TEMP, "full wake");
		step(2);
		check(pd, 1'b1, "sleeps again");
		u_host_model.send(C_FET);
		u_host_model.send(C_WBR);
		step(400);
		check(conv_n, 3, "bridge wake needs i2c");
		u_host_model.send(C_WBR | C_I2C);
		wait_fresh();
		check(ks.size(), 4, "bridge only");
		check(ks[3], MEAS_BRIDGE, "bridge wake");
		$display("test sleep done");
	endtask : t_sleep

	task automatic t_fault();
		cfg_t c;
		c = '0;
		c.nv_locked = 1'b1;
		c.core_clock_sel = 1'b1;
		c.update_rate = 2'h1;
		flt = 1'b1;
		do_reset(c);
		wait_fresh();
		step(1);
		check(result.status, STAT_FAULT, "fault");
		check(dri, 1'b0, "no ready on fault");
		u_host_model.send(C_FET | C_I2C);
		check(result.status, STAT_FAULT, "fault sticks");
		flt = 1'b0;
		$display("test fault done");
	endtask : t_fault

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	// ==========================================================
	// main sequence
	initial begin
		sys_rst = 1'b1;
		cfg = '0;
		bd = '0;
		td = '0;
		flt = 1'b0;
		err_total = 0;
		checks_done = 0;
		cyc = 0;
		n = $urandom(32'h0AD38741);
		t_window();
		for (int r = 0; r < 4; r++) t_update(2'(r), 1'($urandom));
		t_cal();
		t_sleep();
		t_fault();
		results();
	end
endmodule : measurement_mode_sequencer_tb

`default_nettype wire

// file: inc/seq_pkg.sv
// package: constants, types and timing for the measurement mode sequencer
package seq_pkg;

	// ==========================================================
	// clocking
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned CORE_FAST_HZ = 4_000_000;
	localparam int unsigned CORE_SLOW_HZ = 1_000_000;
	localparam int unsigned DIV_FAST     = CLK_HZ / CORE_FAST_HZ;
	localparam int unsigned DIV_SLOW     = CLK_HZ / CORE_SLOW_HZ;
	localparam int unsigned DIV_W        = 6;
	localparam int unsigned CORE_SLOW_NS = 1_000_000_000 / CORE_SLOW_HZ;
	localparam int unsigned CORE_FAST_NS = 1_000_000_000 / CORE_FAST_HZ;

	// ==========================================================
	// times in ns at the 1 MHz core clock; counts are core cycles
	localparam int unsigned WIN_UNLOCK_NS   = 6_000_000;
	localparam int unsigned WIN_LOCK_NS     = 1_500_000;
	localparam int unsigned CONV_NS         = 300_000;
	localparam int unsigned CALC_NS         = 100_000;
	localparam int unsigned FIRST_RESULT_NS = 6_000_000;
	localparam int unsigned WIN_UNLOCK_CYC  = WIN_UNLOCK_NS / CORE_SLOW_NS;
	localparam int unsigned WIN_LOCK_CYC    = WIN_LOCK_NS / CORE_SLOW_NS;
	localparam int unsigned CONV_CYC        = CONV_NS / CORE_SLOW_NS;
	localparam int unsigned CALC_CYC        = CALC_NS / CORE_SLOW_NS;
	localparam int unsigned FIRST_RESULT_CYC = FIRST_RESULT_NS / CORE_SLOW_NS;
	localparam int unsigned TMR_W           = 18;

	// ==========================================================
	// update periods, index {long_integ, core_clock_sel, update_rate}
	typedef int unsigned per_tab_t [16];
	localparam per_tab_t PERIOD_NS = '{
		1_600_000, 5_000_000, 25_000_000, 125_000_000,
		500_000, 1_500_000, 6_500_000, 32_000_000,
		5_000_000, 8_500_000, 30_000_000, 130_000_000,
		1_500_000, 2_500_000, 7_500_000, 33_000_000};

	function automatic per_tab_t period_table();
		per_tab_t t;
		for (int i = 0; i < 16; i++) begin
			t[i] = PERIOD_NS[i] / (((i & 4) != 0) ? CORE_FAST_NS : CORE_SLOW_NS);
		end
		return t;
	endfunction : period_table

	localparam per_tab_t PERIOD_CYC_DEF = period_table();

	// ordinary cycles between special measurements, per update_rate
	localparam logic [7:0] SPECIAL_GAP [4] = '{8'hFF, 8'h7F, 8'h1F, 8'h0F};

	// ==========================================================
	// status codes in the two top bits of the result
	localparam logic [1:0] STAT_VALID = 2'h0;
	localparam logic [1:0] STAT_CMD   = 2'h1;
	localparam logic [1:0] STAT_STALE = 2'h2;
	localparam logic [1:0] STAT_FAULT = 2'h3;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_WINDOW = 3'h0,
		ST_CAL    = 3'h1,
		ST_TEMP   = 3'h2,
		ST_ZERO   = 3'h3,
		ST_BRIDGE = 3'h4,
		ST_CALC   = 3'h5,
		ST_SLEEP  = 3'h6,
		ST_PWRDN  = 3'h7
	} state_t;

	typedef enum logic [1:0] {
		MEAS_NONE   = 2'h0,
		MEAS_TEMP   = 2'h1,
		MEAS_ZERO   = 2'h2,
		MEAS_BRIDGE = 2'h3
	} meas_t;

	typedef struct packed {
		logic       nv_locked;
		logic       sleep_mode;
		logic       long_integ;
		logic       core_clock_sel;
		logic       spi_protocol;
		logic [1:0] update_rate;
	} cfg_t;

	typedef struct packed {
		logic enter_calibration_cmd;
		logic start_normal_cmd;
		logic fetch_result_cmd;
		logic wake_full_measure_cmd;
		logic wake_bridge_only_cmd;
		logic cal_other_cmd;
		logic from_i2c;
	} cmd_t;

	typedef struct packed {
		logic [1:0]  status;
		logic [13:0] bridge;
		logic [7:0]  temp;
	} result_t;

endpackage : seq_pkg
